// ---- testbench/tb.sv ----
// self-checking bench for the vector base and keyed reset control register bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vbrc_pkg::*;

  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic [7:0]  regAddr   = 8'h00;
  logic [31:0] regWdata  = 32'h00000000;
  logic        regWr     = 1'b0;
  logic        regRd     = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] vectorBase;
  logic [2:0]  prioSplit;
  logic        system_reset_request;
  logic [7:0]  candPrio  = 8'h00;
  logic [7:0]  actPrio   = 8'h00;
  logic        actValid  = 1'b0;
  logic        preemptOk;
  int          nMismatch = 0;
  int          checks    = 0;
  // candidate and active levels chosen to straddle group boundaries
  logic [7:0]  candTab [6] = '{8'h20, 8'h40, 8'h7F, 8'h80, 8'h01, 8'h10};
  logic [7:0]  actTab  [6] = '{8'h2F, 8'h3F, 8'h80, 8'h7F, 8'h02, 8'h10};
  logic        validTab[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  // 20 MHz clock
  always #25 clk = ~clk;

  vbrc_sys_ctrl vbrc_sys_ctrl_inst (
    .clk         (clk),
    .srst        (srst),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regWr       (regWr),
    .regRd       (regRd),
    .regRdata    (regRdata),
    .vectorBase  (vectorBase),
    .prioSplit   (prioSplit),
    .system_reset_request (system_reset_request),
    .candPrio    (candPrio),
    .actPrio     (actPrio),
    .actValid    (actValid),
    .preemptOk   (preemptOk)
  );

  // case equality so an unknown never counts as a match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe, effect visible after the write edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(negedge clk);
  endtask

  // read data stand only in the cycle after the strobe, then fall to zero
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, e, "regRdata");
    @(negedge clk);
    chk(regRdata, 32'h00000000, "regRdata idle");
  endtask

  // expected verdict from the group bits only; no active exception always preempts
  task automatic pre(input logic [7:0] c, input logic [7:0] a, input logic v,
                     input logic [2:0] n);
    logic [7:0] m;
    logic       e;
    m = 8'hFF << ({1'b0, n} + 4'h1);
    e = v ? ((c & m) < (a & m)) : 1'b1;
    @(posedge clk);
    candPrio <= c;
    actPrio  <= a;
    actValid <= v;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, preemptOk}, {31'h0, e}, "preemptOk");
  endtask

  task automatic summarize();
    if (nMismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    // reset state of both registers
    chk({28'h0, system_reset_request, prioSplit}, 32'h00000000, "reset outputs");
    rd(OFS_VECTOR_BASE, 32'h00000000);
    rd(OFS_KEYED_RESET, 32'hFA050000);
    // low nine bits of the table offset never store
    wr(OFS_VECTOR_BASE, 32'hFFFFFFFF);
    chk(vectorBase, 32'hFFFFFE00, "vectorBase");
    rd(OFS_VECTOR_BASE, 32'hFFFFFE00);
    wr(OFS_VECTOR_BASE, 32'h12345680);
    rd(OFS_VECTOR_BASE, 32'h12345600);
    // a wrong key must change nothing and request no reset
    wr(OFS_KEYED_RESET, 32'h05FB0704);
    chk({28'h0, system_reset_request, prioSplit}, 32'h00000000, "bad key");
    rd(OFS_KEYED_RESET, 32'hFA050000);
    // unmapped places read zero and take no writes
    wr(8'h10, 32'h05FA0704);
    rd(8'h04, 32'h00000000);
    rd(OFS_VECTOR_BASE, 32'h12345600);
    // software keeps the offset aligned to the table size
    wr(OFS_VECTOR_BASE, 32'h20000400);
    chk(vectorBase, 32'h20000400, "aligned base");
    // every split value, with reserved and read-only bits written high
    for (int n = 0; n < 8; n++) begin
      wr(OFS_KEYED_RESET, 32'h05FAF8F8 | (32'(n) << 8));
      chk({29'h0, prioSplit}, 32'(n), "prioSplit");
      rd(OFS_KEYED_RESET, 32'hFA050000 | (32'(n) << 8));
      for (int k = 0; k < 6; k++) begin
        pre(candTab[k], actTab[k], validTab[k], 3'(n));
      end
    end
    chk({31'h0, system_reset_request}, 32'h00000000, "no request");
    // keyed write of 1 to the request bit raises the held request
    wr(OFS_KEYED_RESET, 32'h05FA0304);
    chk({28'h0, system_reset_request, prioSplit}, 32'h0000000B, "request");
    rd(OFS_KEYED_RESET, 32'hFA050300);
    // writing 0 to the request bit does not drop the held level
    wr(OFS_KEYED_RESET, 32'h05FA0100);
    chk({28'h0, system_reset_request, prioSplit}, 32'h00000009, "request held");
    // a mid-run reset clears everything
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk({28'h0, system_reset_request, prioSplit}, 32'h00000000, "second reset");
    chk(vectorBase, 32'h00000000, "vectorBase reset");
    summarize();
  end
endmodule

// ---- verilog/vbrc_key_gate.sv ----
// decodes register writes and checks the write key
module vbrc_key_gate (
  input  wire logic                          regWr,
  input  wire logic [vbrc_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [vbrc_pkg::DATA_W-1:0]   regWdata,
  output logic                               wrVector,
  output logic                               wrReset
);
  import vbrc_pkg::*;

  // a reset register write with the wrong key is dropped here entirely
  assign wrVector = regWr && (regAddr == OFS_VECTOR_BASE);
  assign wrReset  = regWr && (regAddr == OFS_KEYED_RESET)
                    && (regWdata[KEY_MSB:KEY_LSB] == KEY_WRITE); // [R05] [R12]
endmodule

// ---- verilog/vbrc_pkg.sv ----
// constants and helpers for the vector base and keyed reset control registers
package vbrc_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_VECTOR_BASE = 8'h08;
  localparam logic [7:0] OFS_KEYED_RESET = 8'h0C;

  // vector base register layout
  localparam int unsigned TBL_LSB  = 9;
  localparam int unsigned TBL_MSB  = 31;
  localparam logic [31:0] TBL_MASK = 32'hFFFFFE00;
  localparam logic [31:0] VECTOR_BASE_RST = 32'h00000000;

  // keyed reset control register layout
  localparam int unsigned KEY_LSB    = 16;
  localparam int unsigned KEY_MSB    = 31;
  localparam int unsigned ENDIAN_BIT = 15;
  localparam int unsigned SPLIT_LSB  = 8;
  localparam int unsigned SPLIT_MSB  = 10;
  localparam int unsigned SYSRST_BIT = 2;
  localparam logic [15:0] KEY_WRITE  = 16'h05FA;
  localparam logic [15:0] KEY_READ   = 16'hFA05;
  localparam logic        ENDIAN_LITTLE = 1'h0;
  localparam logic [2:0]  SPLIT_RST  = 3'h0;

  // mask of the group priority bits of an 8-bit priority level for split value n
  function automatic logic [7:0] groupMask(input logic [2:0] split);
    logic [3:0] shift;
    shift = {1'b0, split} + 4'h1;
    return 8'(8'hFF << shift);
  endfunction

endpackage

// ---- verilog/vbrc_prio_split.sv ----
// strips subpriority bits from two priority levels by the split field
module vbrc_prio_split (
  vbrc_split_if.unit bus
);
  import vbrc_pkg::*;

  // only group bits survive; subpriority never takes part in preemption
  assign bus.candGroup = bus.candPrio & groupMask(bus.split); // [R10] [R11]
  assign bus.actGroup  = bus.actPrio & groupMask(bus.split);  // [R10] [R11]
endmodule

// ---- verilog/vbrc_split_if.sv ----
// carrier between the register bank and the priority split unit
interface vbrc_split_if;
  logic [2:0] split;
  logic [7:0] candPrio;
  logic [7:0] actPrio;
  logic [7:0] candGroup;
  logic [7:0] actGroup;

  modport bank (output split, output candPrio, output actPrio,
                input candGroup, input actGroup);
  modport unit (input split, input candPrio, input actPrio,
                output candGroup, output actGroup);
endinterface

// ---- verilog/vbrc_sys_ctrl.sv ----
// vector table base and keyed reset control register bank
// Function
// R01: software reads and writes the vector table base offset from address zero; the code places it at offset 0x08.
// R02: register bits 31..9 hold offset bits 31..9 as the table offset field.
// R03: low nine offset bits are always zero; those register bits are reserved.
// R04: software aligns the offset to the number of vector table entries.
// R05: reset register key in bits 31..16; writes need 0x5FA, reads give 0xFA05.
// R06: bit 15 is read only and reads 0 for little-endian data.
// R07: bits 10..8 hold a read/write three-bit priority split field.
// R08: keyed write of 1 to bit 2 raises the system reset request; reads 0.
// R09: bits 1 and 0 read zero; software writes them as zero.
// R10: split n gives group bits 7..n+1 and subpriority bits n..0.
// R11: preemption compares only group priority bits.
// R12: a wrongly keyed write changes nothing and raises no reset request.
// R13: reserved bits ignore writes and read back as zero.
module vbrc_sys_ctrl (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [vbrc_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [vbrc_pkg::DATA_W-1:0]   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [vbrc_pkg::DATA_W-1:0]   regRdata,
  output logic      [vbrc_pkg::DATA_W-1:0]   vectorBase,
  output logic      [2:0]                    prioSplit,
  output logic                               system_reset_request,
  input  wire logic [7:0]                    candPrio,
  input  wire logic [7:0]                    actPrio,
  input  wire logic                          actValid,
  output logic                               preemptOk
);
  import vbrc_pkg::*;

  logic [DATA_W-1:0] vectorBase_r;
  logic [DATA_W-1:0] vectorBase_nxt;
  logic [2:0]        prioSplit_r;
  logic              system_reset_request_r;
  logic [DATA_W-1:0] regRdata_r;
  logic [DATA_W-1:0] regRdata_nxt;
  logic              preemptOk_r;
  logic              preemptOk_nxt;
  logic              wrVector;
  logic              wrReset;
  logic [DATA_W-1:0] resetRegView;

  vbrc_split_if splitBus ();

  // write decode and key check live in a small leaf
  vbrc_key_gate keyGate (
    .regWr    (regWr),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .wrVector (wrVector),
    .wrReset  (wrReset)
  );

  // group priority extraction
  vbrc_prio_split prioSplitUnit (
    .bus (splitBus)
  );

  assign splitBus.split    = prioSplit_r;
  assign splitBus.candPrio = candPrio;
  assign splitBus.actPrio  = actPrio;

  // ---- vector table base ----

  // only the table offset field is stored; the low nine bits cannot hold a one
  assign vectorBase_nxt = regWdata & TBL_MASK; // [R02] [R03] [R13]

  // base register, software writable at any time
  always_ff @(posedge clk) begin
    if (srst) begin
      vectorBase_r <= VECTOR_BASE_RST;
    end else if (wrVector) begin
      vectorBase_r <= vectorBase_nxt; // [R01] [R02]
    end
  end

  // ---- keyed reset control ----

  // split field only moves on a correctly keyed write
  always_ff @(posedge clk) begin
    if (srst) begin
      prioSplit_r <= SPLIT_RST;
    end else if (wrReset) begin
      prioSplit_r <= regWdata[SPLIT_MSB:SPLIT_LSB]; // [R07] [R12]
    end
  end

  // reset request is held until the outer controller resets us, so a slow
  // reset generator cannot miss it; writing 0 never withdraws it
  always_ff @(posedge clk) begin
    if (srst) begin
      system_reset_request_r <= 1'b0;
    end else if (wrReset && regWdata[SYSRST_BIT]) begin
      system_reset_request_r <= 1'b1; // [R08] [R12]
    end
  end

  // debug bits 1..0 are neither stored nor acted on; a nonzero write is the
  // software fault that the debug logic would see, and here it is simply dropped

  // read view: key pattern, fixed byte order, split field, all else zero
  always_comb begin
    resetRegView = '0;                                   // [R09] [R13]
    resetRegView[KEY_MSB:KEY_LSB] = KEY_READ;            // [R05]
    resetRegView[ENDIAN_BIT] = ENDIAN_LITTLE;            // [R06]
    resetRegView[SPLIT_MSB:SPLIT_LSB] = prioSplit_r;     // [R07]
    resetRegView[SYSRST_BIT] = 1'b0;                     // [R08]
  end

  // ---- register read port ----

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    regRdata_nxt = '0;
    if (regRd) begin
      unique case (regAddr)
        OFS_VECTOR_BASE: regRdata_nxt = vectorBase_r; // [R01] [R03]
        OFS_KEYED_RESET: regRdata_nxt = resetRegView;
        default:         regRdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata_r <= '0;
    end else begin
      regRdata_r <= regRdata_nxt;
    end
  end

  // ---- preemption decision ----

  // lower group value wins; equal groups never preempt, whatever the subpriority
  always_comb begin
    preemptOk_nxt = 1'b1;
    if (actValid) begin
      preemptOk_nxt = splitBus.candGroup < splitBus.actGroup; // [R11]
    end
  end

  // registered so the output is glitch free; costs one cycle of latency
  always_ff @(posedge clk) begin
    if (srst) begin
      preemptOk_r <= 1'b0;
    end else begin
      preemptOk_r <= preemptOk_nxt;
    end
  end

  // outputs straight from flip-flops
  assign regRdata    = regRdata_r;
  assign vectorBase  = vectorBase_r;
  assign prioSplit   = prioSplit_r;
  assign system_reset_request = system_reset_request_r;
  assign preemptOk   = preemptOk_r;

  // ---- checks ----

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (srst);

  // a write to the reset register with the documented key
  sequence s_keyed_write;
    regWr && (regAddr == OFS_KEYED_RESET) && (regWdata[KEY_MSB:KEY_LSB] == KEY_WRITE);
  endsequence

  // a write to the reset register with any other key
  sequence s_bad_key_write;
    regWr && (regAddr == OFS_KEYED_RESET) && (regWdata[KEY_MSB:KEY_LSB] != KEY_WRITE);
  endsequence

  // a read strobe at the reset register address
  sequence s_reset_read;
    regRd && (regAddr == OFS_KEYED_RESET);
  endsequence

  property p_key_split_load;
    s_keyed_write |=> (prioSplit_r == $past(regWdata[SPLIT_MSB:SPLIT_LSB]));
  endproperty
  a_key_split_load: assert property (p_key_split_load) // [R07]
    else $error("split field not loaded by keyed write");

  property p_bad_key_ignored;
    s_bad_key_write ##0 !system_reset_request_r |=> $stable(prioSplit_r) && !system_reset_request_r;
  endproperty
  a_bad_key_ignored: assert property (p_bad_key_ignored) // [R05] [R12]
    else $error("write with wrong key had an effect");

  property p_reset_raise;
    s_keyed_write ##0 regWdata[SYSRST_BIT] |=> system_reset_request_r [*3];
  endproperty
  a_reset_raise: assert property (p_reset_raise) // [R08]
    else $error("reset request not raised and held");

  property p_reset_cause;
    $rose(system_reset_request_r) |-> $past(wrReset) && $past(regWdata[SYSRST_BIT]);
  endproperty
  a_reset_cause: assert property (p_reset_cause) // [R08] [R12]
    else $error("reset request raised without keyed write");

  property p_reset_reg_read;
    s_reset_read |=> (regRdata_r[KEY_MSB:KEY_LSB] == KEY_READ)
      && !regRdata_r[ENDIAN_BIT] && (regRdata_r[14:11] == 4'h0)
      && (regRdata_r[7:0] == 8'h00)
      && (regRdata_r[SPLIT_MSB:SPLIT_LSB] == $past(prioSplit_r));
  endproperty
  a_reset_reg_read: assert property (p_reset_reg_read) // [R05] [R06] [R09] [R13]
    else $error("reset register read value wrong");

  property p_vector_write;
    wrVector |=> (vectorBase_r == ($past(regWdata) & TBL_MASK));
  endproperty
  a_vector_write: assert property (p_vector_write) // [R02] [R03] [R13]
    else $error("vector base not stored as masked write data");

  property p_vector_read;
    regRd && (regAddr == OFS_VECTOR_BASE) |=>
      (regRdata_r == $past(vectorBase_r)) && (regRdata_r[8:0] == 9'h000);
  endproperty
  a_vector_read: assert property (p_vector_read) // [R01] [R03]
    else $error("vector base read value wrong");

  property p_read_only_once;
    !regRd |=> (regRdata_r == '0);
  endproperty
  a_read_only_once: assert property (p_read_only_once)
    else $error("read data present without a read strobe");

  property p_group_only;
    actValid |=> preemptOk_r ==
      (($past(candPrio) >> ({1'b0, $past(prioSplit_r)} + 4'h1))
        < ($past(actPrio) >> ({1'b0, $past(prioSplit_r)} + 4'h1)));
  endproperty
  a_group_only: assert property (p_group_only) // [R11]
    else $error("preemption decision wrong");

  property p_split_width;
    (prioSplit_r == 3'h7) |-> (splitBus.candGroup == 8'h00) && (splitBus.actGroup == 8'h00);
  endproperty
  a_split_width: assert property (p_split_width) // [R10]
    else $error("split 7 left group bits");

  property p_split_zero;
    (prioSplit_r == 3'h0) |-> (splitBus.candGroup == (candPrio & 8'hFE));
  endproperty
  a_split_zero: assert property (p_split_zero) // [R10]
    else $error("split 0 did not keep one subpriority bit");

  // group bits are the level with its n+1 lowest bits cleared
  property p_group_cand;
    splitBus.candGroup ==
      ((candPrio >> ({1'b0, prioSplit_r} + 4'h1)) << ({1'b0, prioSplit_r} + 4'h1));
  endproperty
  a_group_cand: assert property (p_group_cand) // [R10]
    else $error("candidate group bits wrong");

  // the same split applies to the active level
  property p_group_act;
    splitBus.actGroup ==
      ((actPrio >> ({1'b0, prioSplit_r} + 4'h1)) << ({1'b0, prioSplit_r} + 4'h1));
  endproperty
  a_group_act: assert property (p_group_act) // [R10]
    else $error("active group bits wrong");

  // with nothing active any candidate may run
  property p_no_active;
    !actValid |=> preemptOk_r;
  endproperty
  a_no_active: assert property (p_no_active) // [R11]
    else $error("preemption refused with nothing active");

  // the request never drops on its own; only srst clears it
  property p_reset_hold;
    system_reset_request_r |=> system_reset_request_r;
  endproperty
  a_reset_hold: assert property (p_reset_hold) // [R08]
    else $error("reset request withdrawn");

  // the base only moves on a write to its own address
  property p_vector_hold;
    !(regWr && (regAddr == OFS_VECTOR_BASE)) |=> $stable(vectorBase_r);
  endproperty
  a_vector_hold: assert property (p_vector_hold) // [R01] [R13]
    else $error("vector base changed without a write");

  // the split only moves on a correctly keyed write
  property p_split_hold;
    !(regWr && (regAddr == OFS_KEYED_RESET) && (regWdata[KEY_MSB:KEY_LSB] == KEY_WRITE))
      |=> $stable(prioSplit_r);
  endproperty
  a_split_hold: assert property (p_split_hold) // [R07] [R12]
    else $error("split field changed without a keyed write");

  // the nine low offset bits can never hold a one
  property p_vector_low_zero;
    vectorBase_r[8:0] == 9'h000;
  endproperty
  a_vector_low_zero: assert property (p_vector_low_zero) // [R03]
    else $error("vector base low bits not zero");

  // holes in the map read as zero
  property p_unmapped_read;
    regRd && (regAddr != OFS_VECTOR_BASE) && (regAddr != OFS_KEYED_RESET)
      |=> (regRdata_r == '0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // [R13]
    else $error("unmapped read returned data");

  // a rejected key must not leak into the other register either
  property p_bad_key_vector;
    s_bad_key_write |=> $stable(vectorBase_r);
  endproperty
  a_bad_key_vector: assert property (p_bad_key_vector) // [R12]
    else $error("wrong key write changed vector base");

  // a keyed write that sets the request bit
  sequence s_request_write;
    s_keyed_write ##0 regWdata[SYSRST_BIT];
  endsequence

  // soon after raising the request a read still shows the bit as zero
  property p_request_read;
    s_request_write ##[1:4] s_reset_read |=> system_reset_request_r && !regRdata_r[SYSRST_BIT];
  endproperty
  a_request_read: assert property (p_request_read) // [R08]
    else $error("request bit read back as one");

  // the leaf only lets a vector write through at its own address
  property p_wr_decode;
    wrVector |-> regWr && (regAddr == OFS_VECTOR_BASE);
  endproperty
  a_wr_decode: assert property (p_wr_decode) // [R01]
    else $error("vector write decoded at wrong address");

  // the leaf only lets a reset register write through with the right key
  property p_key_gate;
    wrReset |-> regWr && (regAddr == OFS_KEYED_RESET)
      && (regWdata[KEY_MSB:KEY_LSB] == KEY_WRITE);
  endproperty
  a_key_gate: assert property (p_key_gate) // [R05] [R12]
    else $error("reset write passed without the key");

endmodule
